// ### hw/pfs_pkg.sv
/*
 * Shared constants and types for the program flash table sequencer.
 * Assumes a 100 MHz system clock and a 32-bit Avalon-MM register port.
 */
package pfs_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [4:0] OFS_PTR_LOW   = 5'h00;
    localparam logic [4:0] OFS_PTR_HIGH  = 5'h04;
    localparam logic [4:0] OFS_PTR_UPPER = 5'h08;
    localparam logic [4:0] OFS_LATCH     = 5'h0C;
    localparam logic [4:0] OFS_TABLE_OP  = 5'h10;
    localparam logic [4:0] OFS_CONTROL   = 5'h14;
    localparam logic [4:0] OFS_UNLOCK    = 5'h18;
    localparam logic [4:0] OFS_FLAGS     = 5'h1C;

    // ------------------------------------------------------------
    // Field positions and codes
    // ------------------------------------------------------------
    localparam int OP_WRITE_BIT = 0;
    localparam int OP_MODE_LSB  = 1;
    localparam logic [1:0] MODE_KEEP    = 2'h0;
    localparam logic [1:0] MODE_POSTINC = 2'h1;
    localparam logic [1:0] MODE_POSTDEC = 2'h2;
    localparam logic [1:0] MODE_PREINC  = 2'h3;

    localparam logic [7:0] UNLOCK_FIRST  = 8'h55;
    localparam logic [7:0] UNLOCK_SECOND = 8'hAA;
    localparam logic [7:0] HOLD_RESET    = 8'hFF;
    localparam logic [7:0] ERASED_BYTE   = 8'hFF;

    localparam int PTR_W      = 22;
    localparam int PTR_LOW_W  = 21;
    localparam int HOLD_N     = 32;
    localparam int HOLD_AW    = 5;
    localparam int ROW_BYTES  = 64;
    localparam int ROW_SHIFT  = 6;
    localparam int BLK_SHIFT  = 5;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ          = 100;
    localparam int PROG_TIME_US     = 2000;
    localparam int PROG_CYCLES_DEF  = PROG_TIME_US * CLK_MHZ;

    // Control register, bit 7 down to bit 0
    typedef struct packed {
        logic prog_space;
        logic cfg_space;
        logic unused5;
        logic row_erase;
        logic abort;
        logic permit;
        logic start;
        logic unused0;
    } pfs_ctrl_t;

    localparam pfs_ctrl_t CTRL_RESET = '0;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ERASE,
        ST_PROG
    } pfs_state_t;

endpackage

// ### hw/pfs_sequencer.sv
/*
 * Program flash table sequencer: byte pointer, table latch, holding
 * registers, unlock sequence and self-timed erase and programming.
 * Assumes a core issuing Avalon-MM transfers synchronous to clk_sys.
 */
// Implementation choices: the Avalon-MM slave port and the register offsets.
// Function
// - Three byte registers form a 22-bit pointer, low 21 bits address memory.
// - Pointer top bit set selects identification and configuration space.
// - Four pointer modes: keep, post-increment, post-decrement, pre-increment.
// - Automatic pointer updates touch only the low 21 bits.
// - Table read selects one byte using all 22 bits into latch.
// - Reads are byte-wide; address bit 0 picks word high or low.
// - Table write puts latch into holding register chosen by bits 4:0.
// - Programming start uses upper pointer bits to choose the 32-byte block.
// - Erase uses pointer bits 21:6 for the row, ignores bits 5:0.
// - Program-space erase always clears a full 64-byte row; no word or bulk erase.
// - Erase stalls execution about 2 ms, ended by the internal timer.
// - Programming only in 32-byte blocks, no word or byte programming.
// - Table writes only touch holding registers, never the array.
// - Programming starts on start bit, execution halts until timer ends.
// - Holding registers preset to FFh on reset and after programming.
// - FFh leaves a byte unchanged; programming only clears bits.
// - Start bit set-only by software, cleared by hardware on completion.
// - Completion sets the done flag, software clears it.
// - Row-erase select clears automatically when an erase completes.
// - Abort flag on reset mid-cycle or bad start; space selects kept, row-erase select cleared by core reset.
`timescale 1ns/1ps

module pfs_sequencer #(
    parameter int          ARRAY_AW    = 12,
    parameter int unsigned PROG_CYCLES = pfs_pkg::PROG_CYCLES_DEF,
    parameter logic [15:0] ID_WORD     = 16'h5A3C // Arbitrary value
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        rst_por,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             cpu_stall,
    output logic             nvm_done_flag
);
    import pfs_pkg::*;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    localparam int ARRAY_N = 1 << ARRAY_AW;

    // Nonvolatile array, deliberately not reset
    logic [7:0]          flash_mem [ARRAY_N];
    logic [7:0]          hold_q    [HOLD_N];
    logic [PTR_W-1:0]    prog_byte_pointer_q;
    logic [7:0]          table_latch_byte_q;
    pfs_ctrl_t           ctrl_rd;
    logic                permit_q;
    logic                erase_q;
    logic                abort_q;
    logic                prog_q;
    logic                cfg_q;
    logic                done_q;
    logic                armed1_q;
    logic                armed2_q;
    pfs_state_t          state_q;
    logic [31:0]         tmr_q;
    logic [ARRAY_AW-1:0] base_q;
    logic                target_q;
    logic                rd_pend_q;
    logic [31:0]         rdata_q;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic busy;
    logic done_now;
    logic wr_lane;
    logic wr_acc;
    logic ctrl_wr;
    logic start_req;
    logic start_ok;
    logic op_wr;
    logic [7:0] wbyte;

    assign busy     = (state_q != ST_IDLE);
    assign done_now = busy && (tmr_q == 32'(PROG_CYCLES - 1));
    assign wr_lane  = avs_write && avs_byteenable[0];
    assign wbyte    = avs_writedata[7:0];
    assign ctrl_wr  = wr_lane && (avs_address == OFS_CONTROL);
    assign start_req = ctrl_wr && wbyte[1] && !busy;
    assign start_ok = start_req && armed2_q && wbyte[2];

    // Starting write is held until the timer ends, which halts the core
    always_comb begin
        avs_waitrequest = 1'b0;
        if (busy && !done_now) begin
            avs_waitrequest = 1'b1;
        end else if (start_ok) begin
            avs_waitrequest = 1'b1;
        end else if (avs_read && !rd_pend_q) begin
            avs_waitrequest = 1'b1;
        end
    end

    assign wr_acc    = wr_lane && !avs_waitrequest;
    assign op_wr     = wr_acc && (avs_address == OFS_TABLE_OP);
    assign cpu_stall = busy;
    assign nvm_done_flag = done_q;

    // ------------------------------------------------------------
    // Pointer arithmetic and table read source
    // ------------------------------------------------------------
    logic [1:0]         op_mode;
    logic [PTR_W-1:0]   acc_ptr;
    logic [PTR_W-1:0]   next_ptr;
    logic [PTR_LOW_W-1:0] low_inc;
    logic [PTR_LOW_W-1:0] low_dec;
    logic [7:0]         rd_byte;

    assign op_mode = wbyte[OP_MODE_LSB +: 2];
    assign low_inc = prog_byte_pointer_q[PTR_LOW_W-1:0] + 21'h000001;
    assign low_dec = prog_byte_pointer_q[PTR_LOW_W-1:0] - 21'h000001;

    always_comb begin
        acc_ptr  = prog_byte_pointer_q;
        next_ptr = prog_byte_pointer_q;
        case (op_mode)
            MODE_POSTINC: begin
                next_ptr = {prog_byte_pointer_q[PTR_W-1], low_inc};
            end
            MODE_POSTDEC: begin
                next_ptr = {prog_byte_pointer_q[PTR_W-1], low_dec};
            end
            MODE_PREINC: begin
                acc_ptr  = {prog_byte_pointer_q[PTR_W-1], low_inc};
                next_ptr = acc_ptr;
            end
            default: begin
                next_ptr = prog_byte_pointer_q;
            end
        endcase
    end

    always_comb begin
        // all 22 bits select the byte
        if (acc_ptr[PTR_W-1]) begin
            rd_byte = acc_ptr[0] ? ID_WORD[15:8] : ID_WORD[7:0];
            if (acc_ptr[PTR_LOW_W-1:1] != '0) begin
                rd_byte = ERASED_BYTE;
            end
        end else if (acc_ptr[PTR_LOW_W-1:ARRAY_AW] != '0) begin
            rd_byte = ERASED_BYTE;
        end else begin
            // byte-wide, bit 0 picks half of word
            rd_byte = flash_mem[acc_ptr[ARRAY_AW-1:0]];
        end
    end

    // ------------------------------------------------------------
    // Pointer registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prog_byte_pointer_q <= '0;
        end else if (op_wr) begin
            prog_byte_pointer_q <= next_ptr;
        end else if (wr_acc) begin
            if (avs_address == OFS_PTR_LOW) begin
                prog_byte_pointer_q[7:0] <= wbyte;
            end else if (avs_address == OFS_PTR_HIGH) begin
                prog_byte_pointer_q[15:8] <= wbyte;
            end else if (avs_address == OFS_PTR_UPPER) begin
                prog_byte_pointer_q[21:16] <= wbyte[5:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Table latch
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            table_latch_byte_q <= '0;
        end else if (op_wr && !wbyte[OP_WRITE_BIT]) begin
            table_latch_byte_q <= rd_byte;
        end else if (wr_acc && (avs_address == OFS_LATCH)) begin
            table_latch_byte_q <= wbyte;
        end
    end

    // ------------------------------------------------------------
    // Holding registers
    // ------------------------------------------------------------
    for (genvar gi = 0; gi < HOLD_N; gi++) begin : g_hold
        always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
                hold_q[gi] <= HOLD_RESET;
            end else if (done_now && state_q == ST_PROG) begin
                hold_q[gi] <= HOLD_RESET;
            end else if (op_wr && wbyte[OP_WRITE_BIT]
                         && acc_ptr[HOLD_AW-1:0] == HOLD_AW'(gi)) begin
                hold_q[gi] <= table_latch_byte_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Unlock tracking
    // ------------------------------------------------------------
    // Any other accepted write in between breaks the sequence
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            armed1_q <= 1'b0;
            armed2_q <= 1'b0;
        end else if (wr_acc) begin
            armed1_q <= (avs_address == OFS_UNLOCK) && wbyte == UNLOCK_FIRST;
            armed2_q <= (avs_address == OFS_UNLOCK) && armed1_q
                        && wbyte == UNLOCK_SECOND;
        end
    end

    // ------------------------------------------------------------
    // Self-timed cycle
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q  <= ST_IDLE;
            tmr_q    <= '0;
            base_q   <= '0;
            target_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    tmr_q <= '0;
                    if (start_ok) begin
                        state_q  <= wbyte[4] ? ST_ERASE : ST_PROG;
                        // only program space alters the array
                        target_q <= wbyte[7] && !wbyte[6]
                            && !prog_byte_pointer_q[PTR_W-1]
                            && prog_byte_pointer_q[PTR_LOW_W-1:ARRAY_AW]
                               == '0;
                        if (wbyte[4]) begin
                            base_q <= {prog_byte_pointer_q[ARRAY_AW-1:ROW_SHIFT],
                                       ROW_SHIFT'(0)};
                        end else begin
                            base_q <= {prog_byte_pointer_q[ARRAY_AW-1:BLK_SHIFT],
                                       BLK_SHIFT'(0)};
                        end
                    end
                end
                default: begin
                    tmr_q <= tmr_q + 32'h00000001;
                    if (done_now) begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Array update happens once, at the end of the timed cycle
    always_ff @(posedge clk_sys) begin
        if (done_now && target_q) begin
            if (state_q == ST_ERASE) begin
                for (int i = 0; i < ROW_BYTES; i++) begin
                    flash_mem[base_q + ARRAY_AW'(i)] <= ERASED_BYTE;
                end
            end else begin
                for (int i = 0; i < HOLD_N; i++) begin
                    flash_mem[base_q + ARRAY_AW'(i)] <=
                        flash_mem[base_q + ARRAY_AW'(i)] & hold_q[i];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    // Permit and start follow the core reset
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            permit_q <= 1'b0;
            erase_q  <= 1'b0;
        end else begin
            if (ctrl_wr && wr_acc) begin
                permit_q <= wbyte[2];
                erase_q  <= wbyte[4];
            end
            if (done_now && state_q == ST_ERASE) begin
                erase_q <= 1'b0;
            end
        end
    end

    // start reads as the running cycle
    assign ctrl_rd = {prog_q, cfg_q, 1'b0, erase_q, abort_q, permit_q, busy,
                      1'b0};

    // Only power-on clears these, so a core reset mid-cycle stays visible
    always_ff @(posedge clk_sys or posedge rst_por) begin
        if (rst_por) begin
            abort_q <= 1'b0;
            prog_q  <= 1'b0;
            cfg_q   <= 1'b0;
        end else if (!rst) begin
            if (ctrl_wr && wr_acc) begin
                prog_q <= wbyte[7];
                cfg_q  <= wbyte[6];
            end
            if (done_now) begin
                abort_q <= 1'b0;
            end else if (start_ok) begin
                abort_q <= 1'b1;
            end else if (start_req && wr_acc) begin
                abort_q <= 1'b1;
            end else if (ctrl_wr && wr_acc) begin
                abort_q <= wbyte[3];
            end
        end
    end

    // ------------------------------------------------------------
    // Done flag
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            done_q <= 1'b0;
        end else if (done_now) begin
            done_q <= 1'b1;
        end else if (wr_acc && avs_address == OFS_FLAGS) begin
            done_q <= wbyte[0];
        end
    end

    // ------------------------------------------------------------
    // Read data, one wait state
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_pend_q <= 1'b0;
        end else begin
            rd_pend_q <= avs_read && !rd_pend_q;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_q <= '0;
        end else if (avs_read && !rd_pend_q) begin
            rdata_q <= '0;
            if (avs_address == OFS_PTR_LOW) begin
                rdata_q[7:0] <= prog_byte_pointer_q[7:0];
            end else if (avs_address == OFS_PTR_HIGH) begin
                rdata_q[7:0] <= prog_byte_pointer_q[15:8];
            end else if (avs_address == OFS_PTR_UPPER) begin
                rdata_q[5:0] <= prog_byte_pointer_q[21:16];
            end else if (avs_address == OFS_LATCH) begin
                rdata_q[7:0] <= table_latch_byte_q;
            end else if (avs_address == OFS_CONTROL) begin
                rdata_q[7:0] <= ctrl_rd;
            end else if (avs_address == OFS_FLAGS) begin
                rdata_q[0] <= done_q;
            end
        end
    end

    assign avs_readdata = rdata_q;

endmodule

// ### sim/pfs_seq_chk.sv
/*
 * Port checker for the program flash table sequencer.
 * Assumes it is bound to pfs_sequencer and sees only its ports.
 */
`timescale 1ns/1ps

module pfs_seq_chk #(
    parameter int unsigned PROG_CYCLES = 20
) (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        rst_por,
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        cpu_stall,
    input wire logic        nvm_done_flag
);
    import pfs_pkg::*;

    logic        first_q;
    logic        armed_q;
    int unsigned stall_cnt_q;
    wire         acc = avs_write && !avs_waitrequest && avs_byteenable[0];

    // --------
    // Unlock tracking
    // --------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            first_q <= 1'b0;
            armed_q <= 1'b0;
        end else if (acc) begin
            first_q <= avs_address == OFS_UNLOCK
                       && avs_writedata[7:0] == UNLOCK_FIRST;
            armed_q <= avs_address == OFS_UNLOCK && first_q
                       && avs_writedata[7:0] == UNLOCK_SECOND;
        end
    end

    // Counts stall cycles already seen in this run
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            stall_cnt_q <= 0;
        else if (cpu_stall)
            stall_cnt_q <= stall_cnt_q + 1;
        else
            stall_cnt_q <= 0;
    end

    // --------
    // Properties
    // --------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_stall_bound: assert property (
        cpu_stall |-> stall_cnt_q < PROG_CYCLES)
        else $error("stall outlives timer");
    a_stall_cause: assert property (
        $rose(cpu_stall) |-> $past(avs_write)
        && $past(avs_address) == OFS_CONTROL
        && $past(avs_writedata[2:1]) == 2'h3)
        else $error("stall without start write");
    a_stall_unlocked: assert property (
        $rose(cpu_stall) |-> $past(armed_q))
        else $error("stall without unlock");
    a_done_on_end: assert property (
        $fell(cpu_stall) |-> nvm_done_flag)
        else $error("done not set at end");
    a_done_cause: assert property (
        $rose(nvm_done_flag) |-> $past(cpu_stall)
        || ($past(avs_write) && $past(avs_address) == OFS_FLAGS))
        else $error("done set without cause");
    a_read_wait: assert property (
        $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("read latency wrong");
    a_short_write: assert property (
        avs_write && avs_address != OFS_CONTROL |-> !avs_waitrequest)
        else $error("plain write stalled");
    a_refuse_fast: assert property (
        avs_write && avs_address == OFS_CONTROL && avs_writedata[1]
        && !(armed_q && avs_writedata[2])
        |-> !avs_waitrequest ##1 !cpu_stall)
        else $error("refused start ran");
    a_start_slow: assert property (
        $rose(avs_write) && avs_address == OFS_CONTROL && armed_q
        && avs_writedata[2:1] == 2'h3 && avs_byteenable[0]
        |-> avs_waitrequest [*8])
        else $error("start not stalled");
endmodule

// ### sim/pfs_core_model.sv
/*
 * Core-side partner issuing Avalon-MM register transfers.
 * Assumes a slave on clk_sys that answers through waitrequest.
 */
`timescale 1ns/1ps

module pfs_core_model (
    input  wire logic        clk_sys,
    input  wire logic        avs_waitrequest,
    input  wire logic [31:0] avs_readdata,
    output logic      [4:0]  avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic      [31:0] avs_writedata,
    output logic      [3:0]  avs_byteenable,
    output logic             hung
);
    initial begin
        avs_address    = 5'h00;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h00000000;
        avs_byteenable = 4'h0;
        hung           = 1'b0;
    end

    // --------
    // One transfer, held until waitrequest is seen low
    // --------
    task automatic xfer(input logic wr, input logic [4:0] a,
                        input logic [7:0] d, output logic [7:0] q,
                        output int n);
        n = 0;
        @(posedge clk_sys);
        avs_address    <= a;
        avs_read       <= ~wr;
        avs_write      <= wr;
        avs_writedata  <= {24'h000000, d};
        avs_byteenable <= 4'hF;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 1000);
        // Bounded so a wedged slave cannot hang the run
        if (n >= 1000)
            hung = 1'b1;
        q = avs_readdata[7:0];
        avs_read       <= 1'b0;
        avs_write      <= 1'b0;
        // Released lines show junk, not the last value
        avs_address    <= ~a;
        avs_writedata  <= ~{24'h000000, d};
    endtask
endmodule

// ### sim/test_program_flash_table_sequencer.sv
/*
 * Self-checking bench for the program flash table sequencer.
 * Assumes pfs_pkg, the sequencer, its checker and the core model.
 */
`timescale 1ns/1ps

module test_program_flash_table_sequencer;
    import pfs_pkg::*;

    localparam int unsigned PCYC = 20;
    // Arbitrary identification word
    localparam logic [15:0] IDW  = 16'hC3A5;

    typedef struct {
        logic [1:0]  m;
        logic [21:0] p;
        logic [7:0]  l;
        logic [21:0] np;
    } pfs_row_t;

    logic        clk_sys = 1'b0;
    logic        rst;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        cpu_stall;
    logic        nvm_done_flag;
    logic        hung;
    int          n_fail;
    int          checks_done;
    int          n;
    logic [7:0]  q;
    logic [23:0] ptr;
    logic [4:0]  offs [6] = '{OFS_PTR_LOW, OFS_PTR_HIGH, OFS_PTR_UPPER,
                              OFS_LATCH, OFS_CONTROL, OFS_FLAGS};
    pfs_row_t    rows [6] = '{
        '{MODE_KEEP,    22'h200000, IDW[7:0],  22'h200000},
        '{MODE_POSTINC, 22'h200000, IDW[7:0],  22'h200001},
        '{MODE_POSTDEC, 22'h200001, IDW[15:8], 22'h200000},
        '{MODE_PREINC,  22'h200000, IDW[15:8], 22'h200001},
        '{MODE_POSTINC, 22'h3FFFFF, 8'hFF,     22'h200000},
        '{MODE_POSTDEC, 22'h200000, IDW[7:0],  22'h3FFFFF}};

    always #5 clk_sys = ~clk_sys;

    pfs_sequencer #(.ARRAY_AW(8), .PROG_CYCLES(PCYC), .ID_WORD(IDW)) DUT (
        .clk_sys(clk_sys), .rst(rst), .rst_por(rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cpu_stall(cpu_stall),
        .nvm_done_flag(nvm_done_flag));

    pfs_core_model core (
        .clk_sys(clk_sys), .avs_waitrequest(avs_waitrequest),
        .avs_readdata(avs_readdata), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .hung(hung));

    // --------
    // Helpers
    // --------
    task automatic stop_test();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [23:0] e,
                       input logic [23:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] r;
        core.xfer(1'b1, a, d, r, n);
    endtask

    task automatic rd(input logic [4:0] a);
        core.xfer(1'b0, a, 8'h00, q, n);
    endtask

    task automatic setp(input logic [21:0] p);
        wr(OFS_PTR_LOW, p[7:0]);
        wr(OFS_PTR_HIGH, p[15:8]);
        wr(OFS_PTR_UPPER, {2'h0, p[21:16]});
    endtask

    task automatic tchk(input logic [21:0] p, input logic [7:0] e);
        setp(p);
        wr(OFS_TABLE_OP, 8'h00);
        rd(OFS_LATCH);
        chk("array byte", {16'h0000, e}, {16'h0000, q});
    endtask

    // Sets up control, unlocks, then starts
    task automatic go(input logic [7:0] c);
        wr(OFS_CONTROL, c & 8'hFD);
        wr(OFS_UNLOCK, UNLOCK_FIRST);
        wr(OFS_UNLOCK, UNLOCK_SECOND);
        wr(OFS_CONTROL, c);
    endtask

    always @(posedge hung) begin
        n_fail++;
        stop_test();
    end

    // --------
    // Main sequence
    // --------
    initial begin
        rst = 1'b1;
        n_fail = 0;
        checks_done = 0;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (offs[i]) begin
            rd(offs[i]);
            chk("reset reg", 24'h0, {16'h0000, q});
        end
        $display("test reset done");
        foreach (rows[i]) begin
            setp(rows[i].p);
            wr(OFS_TABLE_OP, {5'h00, rows[i].m, 1'b0});
            rd(OFS_LATCH);
            chk("latch", {16'h0, rows[i].l}, {16'h0, q});
            rd(OFS_PTR_LOW);
            ptr[7:0] = q;
            rd(OFS_PTR_HIGH);
            ptr[15:8] = q;
            rd(OFS_PTR_UPPER);
            ptr[23:16] = q;
            chk("pointer", {2'h0, rows[i].np}, ptr);
        end
        $display("test pointer modes done");
        setp(22'h00004F);
        go(8'h96);
        chk("erase wait", 24'(PCYC + 1), 24'(n));
        rd(OFS_CONTROL);
        chk("control", 24'h80, {16'h0, q & 8'hDA});
        rd(OFS_FLAGS);
        chk("done", 24'h1, {16'h0, q});
        for (int a = 'h40; a < 'h80; a += 'h3F)
            tchk(22'(a), ERASED_BYTE);
        $display("test erase done");
        setp(22'h000060);
        wr(OFS_LATCH, 8'h5A);
        wr(OFS_TABLE_OP, 8'h03);
        wr(OFS_LATCH, 8'h3C);
        wr(OFS_TABLE_OP, 8'h03);
        wr(OFS_FLAGS, 8'h00);
        rd(OFS_FLAGS);
        chk("done cleared", 24'h0, {16'h0, q});
        setp(22'h00007F);
        go(8'h86);
        chk("program wait", 24'(PCYC + 1), 24'(n));
        tchk(22'h000060, 8'h5A);
        tchk(22'h000061, 8'h3C);
        tchk(22'h000062, 8'hFF);
        tchk(22'h000040, 8'hFF);
        setp(22'h000060);
        wr(OFS_LATCH, 8'hF0);
        wr(OFS_TABLE_OP, 8'h01);
        go(8'h86);
        tchk(22'h000060, 8'h50);
        tchk(22'h000061, 8'h3C);
        $display("test program done");
        // Missing unlock, broken unlock, permit clear
        for (int k = 0; k < 3; k++) begin
            wr(OFS_FLAGS, 8'h00);
            if (k != 0) begin
                wr(OFS_UNLOCK, UNLOCK_FIRST);
                wr(OFS_UNLOCK, UNLOCK_SECOND);
            end
            if (k == 1)
                wr(OFS_PTR_LOW, 8'h60);
            wr(OFS_CONTROL, (k == 2) ? 8'h82 : 8'h86);
            chk("refused wait", 24'h1, 24'(n));
            rd(OFS_CONTROL);
            chk("abort", 24'h08, {16'h0, q & 8'h08});
            rd(OFS_FLAGS);
            chk("no done", 24'h0, {16'h0, q});
        end
        tchk(22'h000060, 8'h50);
        $display("test refused start done");
        stop_test();
    end
endmodule

bind pfs_sequencer pfs_seq_chk #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
    .clk_sys(clk_sys), .rst(rst), .rst_por(rst_por),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cpu_stall(cpu_stall),
    .nvm_done_flag(nvm_done_flag));
